// ### rtl/mci_pkg.sv
// Package for the module control and indicator block.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package mci_pkg;

  // ------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int MS_PER_S        = 1000;
  localparam int TICK_MS_NS      = 1_000_000;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int MS_CYCLES       = TICK_MS_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int CONV_CHANNELS   = 3;
  localparam int CONV_BITS       = 10;
  localparam int GPIO_PINS       = 8;
  localparam int WAKE_DELAY_BITS = 8;
  localparam int MIN_WAKE_BITS   = 8;
  localparam int MS_CNT_BITS     = 18;
  localparam int SEC_CNT_BITS    = 10;

  // Full-scale converter code maps to this many hundredths of a volt
  localparam logic [CONV_BITS-1:0]  CONV_FULL_CODE = 10'h3ff;
  localparam logic [CONV_BITS-1:0]  CONV_FULL_HUND = 10'h0e6;

  // ------------------------------------------------------------
  // Regulator modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MCI_REG_OFF     = 2'h0,
    MCI_REG_STANDBY = 2'h1,
    MCI_REG_ACTIVE  = 2'h2
  } mci_reg_mode_type;

  // ------------------------------------------------------------
  // Wake handshake states, Gray coded along the usual path
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MCI_WK_IDLE  = 2'h0,
    MCI_WK_DELAY = 2'h1,
    MCI_WK_SEND  = 2'h3,
    MCI_WK_HOLD  = 2'h2
  } mci_wake_state_type;

endpackage : mci_pkg

// ### rtl/mci_top.sv
// Control and indicator logic of a cellular modem, facing the host.
// Assumes on-chip state inputs are on clk; pins and sensor levels are synchronised.
//
// Behaviour
// - Three separate 10-bit converter channel results.
// - Report channel value as volts times hundred.
// - Operating status high when running, low off.
// - Regulator modes off, standby, active; standby default.
// - Off mode disables regulator always.
// - Standby: when operating, low current asleep, full otherwise.
// - Active: full current whenever operating.
// - Assert wake low when host traffic pending.
// - Wait programmable milliseconds before transmitting.
// - Zero delay default, disables wake mechanism.
// - Send after delay, only when flow allows.
// - Wake low while sending, high when done.
// - Minimum wake seconds timed from last transfer.
// - Send without rewake during minimum wake.
// - Antenna present output and query from sensor.
// - Packet status output follows network attach.
// - Transmit indicator low during every burst.
// - Eight pins, each input or output.
module mci_top
  import mci_pkg::*;
(
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               device_operating,
  input  wire logic                               device_sleep,
  input  wire logic [mci_pkg::CONV_CHANNELS*mci_pkg::CONV_BITS-1:0] conv_sample,
  input  wire logic                               converter_read_command,
  input  wire logic [1:0]                         converter_read_channel,
  output logic [mci_pkg::CONV_BITS-1:0]           converter_read_value,
  output logic                                    converter_read_valid,
  input  wire logic                               regulator_mode_command,
  input  wire mci_pkg::mci_reg_mode_type          regulator_mode_value,
  output logic                                    regulator_enable,
  output logic                                    regulator_low_power,
  output logic                                    operating_status_out,
  input  wire logic [mci_pkg::WAKE_DELAY_BITS-1:0] wake_delay_setting,
  input  wire logic [mci_pkg::MIN_WAKE_BITS-1:0]  min_wake_duration_setting,
  input  wire logic                               host_traffic_pending,
  input  wire logic                               serial_rx_activity,
  input  wire logic                               host_cts,
  output logic                                    serial_send_enable,
  output logic                                    host_wake_out,
  input  wire logic                               antenna_sense,
  input  wire logic                               antenna_state_query,
  output logic                                    antenna_present_out,
  output logic                                    antenna_query_value,
  input  wire logic                               packet_attached,
  output logic                                    packet_status_out,
  input  wire logic                               tx_burst_active,
  output logic                                    transmit_burst_indicator,
  input  wire logic [mci_pkg::GPIO_PINS-1:0]      gpio_dir_output,
  input  wire logic [mci_pkg::GPIO_PINS-1:0]      gpio_out_value,
  input  wire logic [mci_pkg::GPIO_PINS-1:0]      gpio_pin_in,
  output logic [mci_pkg::GPIO_PINS-1:0]           gpio_pin_out,
  output logic [mci_pkg::GPIO_PINS-1:0]           gpio_pin_oe_n,
  output logic [mci_pkg::GPIO_PINS-1:0]           gpio_in_value
);
  import mci_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Scale raw code to hundredths of a volt; product fits 20 bits
  function automatic logic [CONV_BITS-1:0] conv_scale(input logic [CONV_BITS-1:0] code);
    logic [2*CONV_BITS-1:0] prod;
    prod = code * CONV_FULL_HUND;
    conv_scale = CONV_BITS'(prod / {10'h000, CONV_FULL_CODE});
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [GPIO_PINS-1:0] gpio_s1;
  logic [GPIO_PINS-1:0] gpio_s2;
  logic                 ant_s1;
  logic                 ant_s2;
  logic                 cts_s1;
  logic                 cts_s2;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gpio_s1 <= '0;
      gpio_s2 <= '0;
      ant_s1  <= 1'b0;
      ant_s2  <= 1'b0;
      cts_s1  <= 1'b0;
      cts_s2  <= 1'b0;
    end
    else
    begin
      gpio_s1 <= gpio_pin_in;
      gpio_s2 <= gpio_s1;
      ant_s1  <= antenna_sense;
      ant_s2  <= ant_s1;
      cts_s1  <= host_cts;
      cts_s2  <= cts_s1;
    end
  end

  // ------------------------------------------------------------
  // Millisecond and second ticks
  // ------------------------------------------------------------
  logic [MS_CNT_BITS-1:0]  ms_cnt;
  logic [MS_CNT_BITS-1:0]  next_ms_cnt;
  logic [SEC_CNT_BITS-1:0] sec_cnt;
  logic [SEC_CNT_BITS-1:0] next_sec_cnt;
  logic                    ms_tick;
  logic                    sec_tick;

  always_comb
  begin
    ms_tick      = (ms_cnt == MS_CNT_BITS'(MS_CYCLES - 1));
    sec_tick     = ms_tick && (sec_cnt == SEC_CNT_BITS'(MS_PER_S - 1));
    next_ms_cnt  = ms_tick ? '0 : ms_cnt + 1'b1;
    next_sec_cnt = sec_cnt;
    if (ms_tick)
      next_sec_cnt = sec_tick ? '0 : sec_cnt + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ms_cnt  <= '0;
      sec_cnt <= '0;
    end
    else
    begin
      ms_cnt  <= next_ms_cnt;
      sec_cnt <= next_sec_cnt;
    end
  end

  // ------------------------------------------------------------
  // Converter read
  // ------------------------------------------------------------
  logic [CONV_BITS-1:0] sel_code;
  logic [CONV_BITS-1:0] next_conv_value;
  logic                 next_conv_valid;

  always_comb
  begin
    sel_code        = '0;
    if (converter_read_channel < 2'(CONV_CHANNELS))
      sel_code = conv_sample[converter_read_channel*CONV_BITS +: CONV_BITS];
    next_conv_valid = converter_read_command;
    next_conv_value = converter_read_command ? conv_scale(sel_code) : converter_read_value;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      converter_read_value <= '0;
      converter_read_valid <= 1'b0;
    end
    else
    begin
      converter_read_value <= next_conv_value;
      converter_read_valid <= next_conv_valid;
    end
  end

  // ------------------------------------------------------------
  // Regulator mode and indicators
  // ------------------------------------------------------------
  mci_reg_mode_type reg_mode;
  mci_reg_mode_type next_reg_mode;
  logic             next_reg_en;
  logic             next_reg_lp;

  always_comb
  begin
    next_reg_mode = reg_mode;
    if (regulator_mode_command)
      next_reg_mode = regulator_mode_value;
    next_reg_en = 1'b0;
    next_reg_lp = 1'b0;
    case (reg_mode)
      MCI_REG_OFF:
      begin
        next_reg_en = 1'b0;
        next_reg_lp = 1'b0;
      end
      MCI_REG_STANDBY:
      begin
        next_reg_en = device_operating;
        next_reg_lp = device_operating && device_sleep;
      end
      MCI_REG_ACTIVE:
      begin
        next_reg_en = device_operating;
        next_reg_lp = 1'b0;
      end
      default:
      begin
        next_reg_en = 1'b0;
        next_reg_lp = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_mode                 <= MCI_REG_STANDBY;
      regulator_enable         <= 1'b0;
      regulator_low_power      <= 1'b0;
      operating_status_out     <= 1'b0;
      antenna_present_out      <= 1'b0;
      antenna_query_value      <= 1'b0;
      packet_status_out        <= 1'b0;
      transmit_burst_indicator <= 1'b1;
      gpio_pin_out             <= '0;
      gpio_pin_oe_n            <= '1;
      gpio_in_value            <= '0;
    end
    else
    begin
      reg_mode                 <= next_reg_mode;
      regulator_enable         <= next_reg_en;
      regulator_low_power      <= next_reg_lp;
      operating_status_out     <= device_operating;
      antenna_present_out      <= ant_s2;
      if (antenna_state_query)
        antenna_query_value <= ant_s2;
      packet_status_out        <= packet_attached;
      transmit_burst_indicator <= ~tx_burst_active;
      gpio_pin_out             <= gpio_out_value & gpio_dir_output;
      gpio_pin_oe_n            <= ~gpio_dir_output;
      gpio_in_value            <= gpio_s2 & ~gpio_dir_output;
    end
  end

  // ------------------------------------------------------------
  // Host wake handshake
  // ------------------------------------------------------------
  // Settings are sampled live; a change mid-delay takes effect on reload only
  mci_wake_state_type      wk_state;
  mci_wake_state_type      next_wk_state;
  logic [WAKE_DELAY_BITS-1:0] delay_cnt;
  logic [WAKE_DELAY_BITS-1:0] next_delay_cnt;
  logic [MIN_WAKE_BITS-1:0]   hold_cnt;
  logic [MIN_WAKE_BITS-1:0]   next_hold_cnt;
  logic                    next_wake_n;
  logic                    next_send_en;
  logic                    traffic;

  always_comb
  begin
    traffic        = host_traffic_pending || serial_rx_activity;
    next_wk_state  = wk_state;
    next_delay_cnt = delay_cnt;
    next_hold_cnt  = hold_cnt;
    next_wake_n    = 1'b1;
    next_send_en   = 1'b0;
    case (wk_state)
      MCI_WK_IDLE:
      begin
        if (host_traffic_pending)
        begin
          if (wake_delay_setting == '0)
          begin
            next_send_en = cts_s2;
          end
          else
          begin
            next_wk_state  = MCI_WK_DELAY;
            next_delay_cnt = wake_delay_setting;
            next_wake_n    = 1'b0;
          end
        end
      end
      MCI_WK_DELAY:
      begin
        next_wake_n = 1'b0;
        if (ms_tick)
          next_delay_cnt = delay_cnt - 1'b1;
        if (ms_tick && delay_cnt == WAKE_DELAY_BITS'(1))
          next_wk_state = MCI_WK_SEND;
      end
      MCI_WK_SEND:
      begin
        next_wake_n  = ~host_traffic_pending;
        next_send_en = host_traffic_pending && cts_s2;
        if (!host_traffic_pending)
        begin
          next_wk_state = MCI_WK_HOLD;
          next_hold_cnt = min_wake_duration_setting;
        end
      end
      MCI_WK_HOLD:
      begin
        next_send_en = host_traffic_pending && cts_s2;
        if (traffic)
          next_hold_cnt = min_wake_duration_setting;
        else if (sec_tick && hold_cnt != '0)
          next_hold_cnt = hold_cnt - 1'b1;
        if (!traffic && (hold_cnt == '0 || wake_delay_setting == '0))
          next_wk_state = MCI_WK_IDLE;
      end
      default:
      begin
        next_wk_state = MCI_WK_IDLE;
      end
    endcase
    if (!device_operating)
    begin
      next_wk_state = MCI_WK_IDLE;
      next_wake_n   = 1'b1;
      next_send_en  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wk_state           <= MCI_WK_IDLE;
      delay_cnt          <= '0;
      hold_cnt           <= '0;
      host_wake_out      <= 1'b1;
      serial_send_enable <= 1'b0;
    end
    else
    begin
      wk_state           <= next_wk_state;
      delay_cnt          <= next_delay_cnt;
      hold_cnt           <= next_hold_cnt;
      host_wake_out      <= next_wake_n;
      serial_send_enable <= next_send_en;
    end
  end

endmodule // mci_top

// ### test/mci_host_model.sv
// Behavioural host processor on the far side of the wake handshake.
// Assumes it shares clk with the block; stall withholds the send grant.
module mci_host_model #(parameter int WAKE_LAT = 4, parameter int HOLD_LAT = 64)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic host_wake_out,
  input  wire logic operating_status_out,
  input  wire logic stay_awake,
  input  wire logic stall,
  output logic      host_cts
);
  timeunit 1ns;
  timeprecision 1ps;
  int   wake_cnt;
  int   idle_cnt;
  logic awake;
  // Serial side needs a few cycles to leave its own low-power mode
  // Stays awake a while after release; stands in for the minimum wake time
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wake_cnt <= 0;
      idle_cnt <= 0;
      awake    <= 1'b0;
    end
    else if (host_wake_out)
    begin
      wake_cnt <= 0;
      if (idle_cnt == HOLD_LAT)
        awake <= 1'b0;
      else
        idle_cnt <= idle_cnt + 1;
    end
    else
    begin
      idle_cnt <= 0;
      if (wake_cnt == WAKE_LAT)
        awake <= 1'b1;
      else
        wake_cnt <= wake_cnt + 1;
    end
  end
  // Held low while the device is not operating
  assign host_cts = operating_status_out && (awake || stay_awake) && !stall;
endmodule // mci_host_model

// ### test/mci_top_sva.sv
// Port-level checks for mci_top, bound into every instance.
// Assumes the single clk domain and the synchronous active-high rst.
module mci_top_sva
  import mci_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      device_operating,
  input wire logic                      converter_read_command,
  input wire logic [1:0]                converter_read_channel,
  input wire logic [9:0]                converter_read_value,
  input wire logic                      converter_read_valid,
  input wire logic                      regulator_mode_command,
  input wire mci_pkg::mci_reg_mode_type regulator_mode_value,
  input wire logic                      regulator_enable,
  input wire logic                      regulator_low_power,
  input wire logic                      operating_status_out,
  input wire logic [7:0]                wake_delay_setting,
  input wire logic                      host_traffic_pending,
  input wire logic                      host_cts,
  input wire logic                      serial_send_enable,
  input wire logic                      host_wake_out,
  input wire logic                      tx_burst_active,
  input wire logic                      transmit_burst_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_status_follow: assert property (device_operating |=> operating_status_out)
    else $error("status output missed operating");
  a_conv_answer: assert property (converter_read_command |=> converter_read_valid)
    else $error("no converter answer");
  a_conv_bad_chan:
    assert property (converter_read_command && converter_read_channel == 2'h3 |=> converter_read_value == 10'h000)
    else $error("channel three not zero");
  a_reg_off_mode:
    assert property (regulator_mode_command && regulator_mode_value == MCI_REG_OFF ##1 !regulator_mode_command
      |=> !regulator_enable && !regulator_low_power)
    else $error("regulator on in off mode");
  a_reg_active_full:
    assert property ((regulator_mode_command && regulator_mode_value == MCI_REG_ACTIVE && device_operating)
      ##1 (!regulator_mode_command && device_operating) [*2] |-> regulator_enable && !regulator_low_power)
    else $error("regulator not full in active mode");
  a_wake_disabled: assert property (wake_delay_setting == 8'h00 && host_wake_out |=> host_wake_out)
    else $error("wake asserted with zero delay");
  a_send_needs_cts: assert property (!host_cts [*5] |-> !serial_send_enable)
    else $error("send without flow grant");
  a_wake_no_early: assert property ($fell(host_wake_out) |-> !serial_send_enable ##1 !serial_send_enable)
    else $error("send before wake delay");
  a_wake_holds: assert property (host_traffic_pending && !host_wake_out && device_operating |=> !host_wake_out)
    else $error("wake released while sending");
  a_wake_release: assert property (!host_traffic_pending && !host_wake_out |-> ##[1:2] host_wake_out)
    else $error("wake not released after sending");
  a_burst_low: assert property (tx_burst_active |=> !transmit_burst_indicator)
    else $error("burst indicator not low");

  c_conv_read: cover property (converter_read_valid);
  c_wake_fell: cover property ($fell(host_wake_out));
  c_wake_send: cover property (serial_send_enable && !host_wake_out);
endmodule // mci_top_sva

bind mci_top mci_top_sva chk (.*);

// ### test/mci_top_tb.sv
// Self-checking bench for mci_top with a behavioural host.
// Assumes the package timebase; the wake run spans about one millisecond.
module mci_top_tb;
  import mci_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0, rst = 1'b1, device_operating = 1'b1, device_sleep = 1'b1;
  logic             converter_read_command = 1'b0, regulator_mode_command = 1'b0, stay_awake = 1'b0, stall = 1'b0;
  logic             host_traffic_pending = 1'b0, serial_rx_activity = 1'b0, antenna_sense = 1'b0;
  logic             antenna_state_query = 1'b0, packet_attached = 1'b0, tx_burst_active = 1'b0;
  logic [1:0]       converter_read_channel = 2'h0;
  logic [7:0]       wake_delay_setting = 8'h00, min_wake_duration_setting = 8'h00;
  logic [7:0]       gpio_dir_output = 8'h00, gpio_out_value = 8'h00, gpio_pin_in = 8'h00;
  logic [29:0]      conv_sample = 30'h0;
  mci_reg_mode_type regulator_mode_value = MCI_REG_STANDBY;
  logic [9:0]       converter_read_value;
  logic             converter_read_valid, regulator_enable, regulator_low_power, operating_status_out, host_cts;
  logic             serial_send_enable, host_wake_out, antenna_present_out, antenna_query_value;
  logic             packet_status_out, transmit_burst_indicator;
  logic [7:0]       gpio_pin_out, gpio_pin_oe_n, gpio_in_value;
  int               mismatches = 0, samples_checked = 0;

  mci_top dut (.*);
  mci_host_model host (.*);

  always #2.5 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_status;
    @(posedge clk) device_operating <= 1'b0;
    cyc(3);
    chk(operating_status_out, 1'b0);
    chk(regulator_enable, 1'b0);
    @(posedge clk) device_operating <= 1'b1;
    cyc(2);
    chk(operating_status_out, 1'b1);
  endtask

  task automatic t_reg;
    mci_reg_mode_type m [3] = '{MCI_REG_OFF, MCI_REG_ACTIVE, MCI_REG_STANDBY};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk)
      begin
        regulator_mode_command <= 1'b1;
        regulator_mode_value   <= m[i];
      end
      @(posedge clk) regulator_mode_command <= 1'b0;
      for (int s = 0; s < 2; s++)
      begin
        @(posedge clk) device_sleep <= s[0];
        cyc(3);
        chk({regulator_enable, regulator_low_power}, (m[i] == MCI_REG_OFF) ? 2'h0 :
            {1'b1, m[i] == MCI_REG_STANDBY && s == 1});
      end
    end
  endtask

  task automatic t_conv;
    logic [9:0] code [4] = '{10'h3ff, 10'h200, 10'h0c8, 10'h000};
    @(posedge clk) conv_sample <= {code[2], code[1], code[0]};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk)
      begin
        converter_read_command <= 1'b1;
        converter_read_channel <= 2'(i);
      end
      @(posedge clk) converter_read_command <= 1'b0;
      #1;
      chk(converter_read_valid, 1'b1);
      chk(converter_read_value, 10'(int'(code[i]) * int'(CONV_FULL_HUND) / int'(CONV_FULL_CODE)));
    end
    cyc(1);
    chk(converter_read_valid, 1'b0);
  endtask

  task automatic t_indic;
    @(posedge clk)
    begin
      {antenna_sense, packet_attached, tx_burst_active} <= 3'h7;
      gpio_dir_output <= 8'h0f;
      gpio_out_value  <= 8'h5a;
      gpio_pin_in     <= 8'hc3;
      antenna_state_query <= 1'b1;
    end
    @(posedge clk) antenna_state_query <= 1'b0;
    cyc(4);
    chk({antenna_present_out, packet_status_out, transmit_burst_indicator}, 3'h6);
    chk({gpio_pin_oe_n, gpio_pin_out, gpio_in_value}, 24'hf00ac0);
    @(posedge clk) antenna_state_query <= 1'b1;
    @(posedge clk)
    begin
      antenna_state_query <= 1'b0;
      {antenna_sense, packet_attached, tx_burst_active} <= 3'h0;
    end
    cyc(4);
    chk({antenna_query_value, antenna_present_out, packet_status_out, transmit_burst_indicator}, 4'h9);
  endtask

  task automatic t_wake_off;
    @(posedge clk) {stay_awake, host_traffic_pending} <= 2'h3;
    cyc(8);
    chk({host_wake_out, serial_send_enable}, 2'h3);
    @(posedge clk) stall <= 1'b1;
    cyc(8);
    chk(serial_send_enable, 1'b0);
    @(posedge clk) {stay_awake, stall, host_traffic_pending} <= 3'h0;
    cyc(4);
  endtask

  task automatic t_wake;
    int n;
    @(posedge clk)
    begin
      wake_delay_setting   <= 8'h01;
      host_traffic_pending <= 1'b1;
    end
    cyc(1);
    chk(host_wake_out, 1'b0);
    for (n = 0; n < MS_CYCLES + 8 && serial_send_enable !== 1'b1; n++)
      cyc(1);
    chk(serial_send_enable, 1'b1);
    chk(host_wake_out, 1'b0);
    if (n >= MS_CYCLES + 8)
      end_of_test();
    @(posedge clk)
    begin
      host_traffic_pending      <= 1'b0;
      min_wake_duration_setting <= 8'h01;
    end
    cyc(3);
    chk(host_wake_out, 1'b1);
    @(posedge clk) host_traffic_pending <= 1'b1;
    cyc(4);
    chk({host_wake_out, serial_send_enable}, 2'h3);
    @(posedge clk) host_traffic_pending <= 1'b0;
    cyc(2);
    chk(serial_send_enable, 1'b0);
    @(posedge clk) serial_rx_activity <= 1'b1;
    @(posedge clk) serial_rx_activity <= 1'b0;
    cyc(3);
    chk(host_wake_out, 1'b1);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk({host_wake_out, transmit_burst_indicator, gpio_pin_oe_n}, 10'h3ff);
    cyc(3);
    chk({regulator_enable, regulator_low_power}, 2'h3);
    t_status();
    t_reg();
    t_conv();
    t_indic();
    t_wake_off();
    t_wake();
    end_of_test();
  end
endmodule // mci_top_tb
